// ---- rtl/sdl_pkg.sv ----
// constants shared by the stream delay line and its register slave
// assumes one 50 MHz clock and an axi4-lite master on the register port
package sdl_pkg;

  // build-time limits and defaults of the delay path
  localparam int unsigned DELAY_DEPTH_MAX   = 16;
  localparam int unsigned DELAY_DEPTH_DEF   = 1;
  localparam int unsigned DATA_W_MAX        = 512;
  localparam int unsigned DATA_W_DEF        = 8;
  localparam int unsigned SYMBOL_W_DEF      = 8;
  localparam int unsigned CHANNEL_W_MAX     = 8;
  localparam int unsigned CHANNEL_W_DEF     = 1;
  localparam int unsigned CHANNEL_LIMIT_MAX = 255;
  localparam int unsigned CHANNEL_LIMIT_DEF = 1;
  localparam int unsigned ERROR_W_MAX       = 31;
  localparam int unsigned ERROR_W_DEF       = 1;

  // register bus geometry
  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;
  localparam int unsigned AXI_STRB_W = 4;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] STATUS_OFFSET   = 8'h04;
  localparam logic [7:0] BEAT_CNT_OFFSET = 8'h08;
  localparam logic [7:0] PKT_CNT_OFFSET  = 8'h0c;
  localparam logic [7:0] ERR_CNT_OFFSET  = 8'h10;

  // control fields
  localparam int unsigned CTRL_COUNT_EN_BIT = 0;
  localparam int unsigned CTRL_CLEAR_BIT    = 1;
  localparam logic        CTRL_COUNT_EN_RST = 1'h1;

  // status fields
  localparam int unsigned STATUS_PRIMED_BIT    = 0;
  localparam int unsigned STATUS_CHAN_OVER_BIT = 1;
  localparam int unsigned STATUS_DEPTH_LSB     = 8;
  localparam int unsigned DEPTH_FIELD_W        = 5;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- rtl/sdl_beat_if.sv ----
// flat beat word passed between the delay line top and its shift stages
// assumes both ends run on the same clock
interface sdl_beat_if #(
  parameter int unsigned WORD_W = 1
);
  logic [WORD_W-1:0] in_word;
  logic [WORD_W-1:0] out_word;

  modport feeder  (output in_word, input out_word);
  modport shifter (input in_word, output out_word);
endinterface

// ---- rtl/sdl_shift.sv ----
// fixed-depth shift register carrying one packed beat word per stage
// assumes a synchronous active-low reset on the same clock
module sdl_shift #(
  parameter int unsigned DEPTH  = sdl_pkg::DELAY_DEPTH_DEF,
  parameter int unsigned WORD_W = 1
) (
  input wire logic   aclk,
  input wire logic   aresetn,
  sdl_beat_if.shifter beat
);

  generate
    if (DEPTH == 0) begin : g_wire
      // no stage at all; reset still forces the outputs low
      assign beat.out_word = aresetn ? beat.in_word : '0;
    end else begin : g_reg
      typedef struct packed {
        logic [DEPTH-1:0][WORD_W-1:0] stage;
      } sdl_shift_state_t;

      sdl_shift_state_t s_q;
      sdl_shift_state_t s_d;

      // every stage moves each cycle: no backpressure to honour
      always_comb begin
        s_d          = s_q;
        s_d.stage[0] = beat.in_word;
        for (int i = 1; i < DEPTH; i++) begin
          s_d.stage[i] = s_q.stage[i-1];
        end
        // clearing all stages gives the zero hold after release
        if (!aresetn) begin
          s_d = '0;
        end
      end

      always_ff @(posedge aclk) begin
        s_q <= s_d;
      end

      assign beat.out_word = s_q.stage[DEPTH-1];
    end
  endgenerate

endmodule

// ---- rtl/sdl_top.sv ----
// streaming delay line with an axi4-lite statistics and control slave
// assumes upstream source and downstream sink share aclk, no ready used
//
// Operation
// - delay_depth is a build constant from 0 to 16, default 1
// - every accepted beat leaves exactly delay_depth cycles later, unchanged
// - each change of upstream_valid reaches downstream_valid delay_depth later
// - reset is sampled on the rising clock edge; at depth zero it gates the outputs at once
// - while reset is held all outputs, valid, data and sideband, are zero
// - after release outputs stay zero for delay_depth cycles
// - no ready exists; sink takes every beat, source is never stalled
// - data width is a build parameter 1 to 512, default 8
// - symbol width is a build parameter 1 to 512, default 8
// - packet option adds start, end and empty to the delay
// - channel option delays a 0-8 bit channel, limit 0-255
// - error option delays a 0-31 bit error; width zero means none
// - depth zero passes inputs straight through in the same cycle
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
module sdl_top #(
  parameter int unsigned delay_depth           = sdl_pkg::DELAY_DEPTH_DEF,
  parameter int unsigned data_width            = sdl_pkg::DATA_W_DEF,
  parameter int unsigned symbol_width          = sdl_pkg::SYMBOL_W_DEF,
  parameter bit          packet_signals_enable = 1'b0,
  parameter bit          channel_signal_enable = 1'b0,
  parameter int unsigned channel_field_width   = sdl_pkg::CHANNEL_W_DEF,
  parameter int unsigned channel_count_limit   = sdl_pkg::CHANNEL_LIMIT_DEF,
  parameter bit          error_signal_enable   = 1'b0,
  parameter int unsigned error_field_width     = sdl_pkg::ERROR_W_DEF,
  // derived widths; a field of width zero still keeps one dead bit
  localparam int unsigned SYM_PER_BEAT =
    (data_width / symbol_width > 0) ? data_width / symbol_width : 1,
  localparam int unsigned EMPTY_W =
    (SYM_PER_BEAT > 1) ? $clog2(SYM_PER_BEAT) : 1,
  localparam int unsigned CH_W =
    (channel_field_width > 0) ? channel_field_width : 1,
  localparam int unsigned ER_W =
    (error_field_width > 0) ? error_field_width : 1
) (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  // register slave
  input  wire logic [sdl_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [sdl_pkg::AXI_DATA_W-1:0]  s_axi_wdata,
  input  wire logic [sdl_pkg::AXI_STRB_W-1:0]  s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [sdl_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [sdl_pkg::AXI_DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  // upstream stream, no ready
  input  wire logic                            upstream_valid,
  input  wire logic [data_width-1:0]           upstream_data,
  input  wire logic                            upstream_startofpacket,
  input  wire logic                            upstream_endofpacket,
  input  wire logic [EMPTY_W-1:0]              upstream_empty,
  input  wire logic [CH_W-1:0]                 upstream_channel,
  input  wire logic [ER_W-1:0]                 upstream_error,
  // downstream stream, no ready
  output logic                                 downstream_valid,
  output logic [data_width-1:0]                downstream_data,
  output logic                                 downstream_startofpacket,
  output logic                                 downstream_endofpacket,
  output logic [EMPTY_W-1:0]                   downstream_empty,
  output logic [CH_W-1:0]                      downstream_channel,
  output logic [ER_W-1:0]                      downstream_error
);

  // beat word, msb first: valid, data, sop, eop, empty, channel, error
  // the unpack further down must keep exactly the same order
  localparam int unsigned WORD_W = 1 + data_width + 2 + EMPTY_W + CH_W + ER_W;
  localparam int unsigned AW     = sdl_pkg::AXI_ADDR_W;
  localparam int unsigned DW     = sdl_pkg::AXI_DATA_W;
  localparam int unsigned PW     = sdl_pkg::DEPTH_FIELD_W;

  // option gates; a zero width disables its field just like the flag
  localparam bit PKT_ON = packet_signals_enable;
  localparam bit CH_ON  = channel_signal_enable &&
                          (channel_field_width != 0);
  localparam bit ER_ON  = error_signal_enable &&
                          (error_field_width != 0);

  localparam logic [PW-1:0] DEPTH_V     = PW'(delay_depth);
  localparam logic [8:0]    CH_LIMIT_V  = 9'(channel_count_limit);

  // register-side state in one word; the delay stages live in u_shift
  // counters are 32 bits and wrap silently, so software must poll in time
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [DW-1:0]     rdata;
    logic              aw_held;
    logic [AW-1:0]     aw_addr;
    logic              w_held;
    logic [DW-1:0]     w_data;
    logic [3:0]        w_strb;
    logic              count_en;
    logic [PW-1:0]     prime;
    logic              primed;
    logic [DW-1:0]     beat_cnt;
    logic [DW-1:0]     pkt_cnt;
    logic [DW-1:0]     err_cnt;
    logic              chan_over;
  } sdl_top_state_t;

  sdl_top_state_t s_q;
  sdl_top_state_t s_d;

  sdl_beat_if #(.WORD_W(WORD_W)) beat ();

  // pack the input beat; disabled sideband travels as zero
  // forcing it here keeps stray input bits out of the counters
  assign beat.in_word = {
    upstream_valid,
    upstream_data,
    PKT_ON ? upstream_startofpacket : 1'b0,
    PKT_ON ? upstream_endofpacket   : 1'b0,
    PKT_ON ? upstream_empty         : {EMPTY_W{1'b0}},
    CH_ON  ? upstream_channel       : {CH_W{1'b0}},
    ER_ON  ? upstream_error         : {ER_W{1'b0}}
  };

  // the delay itself; stages are the flip-flops driving the outputs
  // with depth zero the shift module shrinks to a reset-gated wire
  sdl_shift #(
    .DEPTH  (delay_depth),
    .WORD_W (WORD_W)
  ) u_shift (
    .aclk    (aclk),
    .aresetn (aresetn),
    .beat    (beat)
  );

  // unpack; no ready port anywhere, so nothing can stall the path
  // only the depth-zero path leaves the outputs without a flip-flop
  assign {
    downstream_valid,
    downstream_data,
    downstream_startofpacket,
    downstream_endofpacket,
    downstream_empty,
    downstream_channel,
    downstream_error
  } = beat.out_word;

  // register file, counters and bus handshakes in one next-state process
  always_comb begin
    logic          do_clear;
    logic          wr_hit;
    logic [AW-1:0] rd_addr;
    logic [AW-1:0] wr_addr;
    s_d      = s_q;
    do_clear = 1'b0;
    wr_hit   = 1'b0;
    // address bits 1:0 are ignored, so any byte offset hits its word
    rd_addr  = {s_axi_araddr[AW-1:2], 2'h0};
    wr_addr  = {s_q.aw_addr[AW-1:2], 2'h0};

    // address and data may arrive in either order; hold each one
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end

    // perform the write once both halves are in and no answer pends
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = sdl_pkg::RESP_OKAY;
      wr_hit      = 1'b1;
      case (wr_addr)
        sdl_pkg::CTRL_OFFSET: begin
          // both control fields sit in byte 0, so only its strobe counts
          if (s_q.w_strb[0]) begin
            s_d.count_en = s_q.w_data[sdl_pkg::CTRL_COUNT_EN_BIT];
            do_clear     = s_q.w_data[sdl_pkg::CTRL_CLEAR_BIT];
          end
        end
        sdl_pkg::STATUS_OFFSET,
        sdl_pkg::BEAT_CNT_OFFSET,
        sdl_pkg::PKT_CNT_OFFSET,
        sdl_pkg::ERR_CNT_OFFSET: begin
          s_d.bresp = sdl_pkg::RESP_OKAY; // read-only, write ignored
        end
        default: begin
          s_d.bresp = sdl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // clear first, so a beat in the same cycle still counts
    // do_clear lives one cycle only, so the clear needs no self-clearing
    // counters watch the delayed side: a beat counts when it leaves, and
    // beats still inside the delay at a clear are counted afterwards
    if (do_clear) begin
      s_d.beat_cnt  = '0;
      s_d.pkt_cnt   = '0;
      s_d.err_cnt   = '0;
      s_d.chan_over = 1'b0;
    end
    if (s_q.count_en && downstream_valid) begin
      s_d.beat_cnt = s_d.beat_cnt + 1'b1;
      if (downstream_endofpacket) begin
        s_d.pkt_cnt = s_d.pkt_cnt + 1'b1;
      end
      if (downstream_error != '0) begin
        s_d.err_cnt = s_d.err_cnt + 1'b1;
      end
    end
    // channel beyond the configured limit is flagged, not dropped
    // the flag is sticky until software clears it through ctrl
    if (CH_ON && downstream_valid &&
        (9'(downstream_channel) > CH_LIMIT_V)) begin
      s_d.chan_over = 1'b1;
    end

    // primed once the zero hold after reset has run out
    // with depth zero the flag is already set by reset itself
    if (s_q.prime != DEPTH_V) begin
      s_d.prime = s_q.prime + 1'b1;
    end
    s_d.primed = (s_d.prime == DEPTH_V);

    // read channel: one read in flight, answer the cycle after accept
    // rdata stays as it is after the handshake; only rvalid drops
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = sdl_pkg::RESP_OKAY;
      s_d.rdata  = '0;
      case (rd_addr)
        sdl_pkg::CTRL_OFFSET: begin
          s_d.rdata[sdl_pkg::CTRL_COUNT_EN_BIT] = s_q.count_en;
        end
        sdl_pkg::STATUS_OFFSET: begin
          s_d.rdata[sdl_pkg::STATUS_PRIMED_BIT]    = s_q.primed;
          s_d.rdata[sdl_pkg::STATUS_CHAN_OVER_BIT] = s_q.chan_over;
          s_d.rdata[sdl_pkg::STATUS_DEPTH_LSB +: PW] = DEPTH_V;
        end
        sdl_pkg::BEAT_CNT_OFFSET: s_d.rdata = s_q.beat_cnt;
        sdl_pkg::PKT_CNT_OFFSET:  s_d.rdata = s_q.pkt_cnt;
        sdl_pkg::ERR_CNT_OFFSET:  s_d.rdata = s_q.err_cnt;
        // unmapped words read zero with an error response
        default: begin
          s_d.rresp = sdl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // readies registered so the bus outputs come from flip-flops
    // wr_hit holds them low in the cycle the write is performed, so a
    // second write cannot slip in before bvalid rises
    s_d.awready = !s_d.aw_held && !s_d.bvalid && !wr_hit;
    s_d.wready  = !s_d.w_held && !s_d.bvalid && !wr_hit;
    s_d.arready = !s_d.rvalid;

    // synchronous reset: counters, bus state and prime counter cleared
    // count_en comes up set so statistics run without any setup
    if (!aresetn) begin
      s_d          = '0;
      s_d.awready  = 1'b1;
      s_d.wready   = 1'b1;
      s_d.arready  = 1'b1;
      s_d.count_en = sdl_pkg::CTRL_COUNT_EN_RST;
      s_d.primed   = (DEPTH_V == '0);
    end
  end

  // one register for the whole state word keeps reset handling uniform
  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  // bus outputs straight from the state register
  // a response code means something only while its valid is high
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = s_q.rdata;

endmodule

// ---- testbench/sdl_top_chk_sva.sv ----
// port checks for the delay line and its register slave
// assumes bind into sdl_top, one clock, aresetn synchronous active low
module sdl_top_chk #(
  parameter int DD = 1,
  parameter int DW = 8
) (
  input wire logic                             aclk,
  input wire logic                             aresetn,
  input wire logic                             s_axi_awvalid,
  input wire logic                             s_axi_awready,
  input wire logic                             s_axi_wvalid,
  input wire logic                             s_axi_wready,
  input wire logic                             s_axi_bvalid,
  input wire logic                             s_axi_bready,
  input wire logic [1:0]                       s_axi_bresp,
  input wire logic                             s_axi_arvalid,
  input wire logic                             s_axi_arready,
  input wire logic                             s_axi_rvalid,
  input wire logic                             s_axi_rready,
  input wire logic [sdl_pkg::AXI_DATA_W-1:0]   s_axi_rdata,
  input wire logic                             upstream_valid,
  input wire logic [DW-1:0]                    upstream_data,
  input wire logic                             downstream_valid,
  input wire logic [DW-1:0]                    downstream_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // edges seen out of reset; saturates so a long run never wraps
  logic [4:0] run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      run_q <= 5'h00;
    else if (run_q != 5'h1f)
      run_q <= run_q + 5'h01;
  end

  default clocking cb @(posedge aclk);
  endclocking

  a_valid_delay: assert property (disable iff (!aresetn)
    run_q >= DD |-> downstream_valid == $past(upstream_valid, DD))
    else $error("valid not delayed by depth");
  a_data_delay: assert property (disable iff (!aresetn)
    run_q >= DD |-> downstream_data == $past(upstream_data, DD))
    else $error("data not delayed by depth");
  a_zero_in_reset: assert property (!aresetn |=>
    !downstream_valid && downstream_data == '0)
    else $error("outputs not zero after reset edge");
  a_zero_after_rel: assert property (disable iff (!aresetn)
    run_q < DD |-> !downstream_valid && downstream_data == '0)
    else $error("outputs not held zero after release");
  a_b_hold: assert property (disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_block: assert property (disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_answer: assert property (disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer not two cycles after both halves");
  a_rst_ready: assert property (!aresetn |=>
    s_axi_awready && s_axi_wready && s_axi_arready && !s_axi_bvalid &&
    !s_axi_rvalid)
    else $error("bus state wrong after reset edge");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_rerst: cover property (aresetn ##1 !aresetn [*2] ##1 aresetn);
endmodule

bind sdl_top sdl_top_chk #(.DD(delay_depth), .DW(data_width)) u_chk (.*);

// ---- testbench/sdl_st_partner.sv ----
// random upstream source standing in front of the delay line
// assumes the sink side takes every beat, so no ready is modelled
module sdl_st_partner #(
  parameter int DW = 8,
  parameter int CW = 1,
  parameter int EW = 1
) (
  input wire logic      aclk,
  input wire logic      run,
  output logic          upstream_valid,
  output logic [DW-1:0] upstream_data,
  output logic          upstream_startofpacket,
  output logic          upstream_endofpacket,
  output logic          upstream_empty,
  output logic [CW-1:0] upstream_channel,
  output logic [EW-1:0] upstream_error
);
  timeunit 1ns;
  timeprecision 1ps;

  // defined levels from time zero
  initial begin
    {upstream_valid, upstream_data, upstream_startofpacket} = '0;
    {upstream_endofpacket, upstream_empty} = '0;
    {upstream_channel, upstream_error} = '0;
  end

  // random gaps; nothing stalls us, so a beat is never held back
  always @(posedge aclk) begin
    if (run && $urandom_range(3) != 0) begin
      upstream_valid         <= 1'b1;
      upstream_data          <= DW'($urandom);
      upstream_startofpacket <= 1'($urandom);
      upstream_endofpacket   <= 1'($urandom);
      upstream_empty         <= 1'($urandom);
      upstream_channel       <= CW'($urandom);
      upstream_error         <= EW'($urandom);
    end else begin
      // an idle data line shows the inverse, never a stale copy
      upstream_valid         <= 1'b0;
      upstream_data          <= ~upstream_data;
      upstream_startofpacket <= 1'b0;
      upstream_endofpacket   <= 1'b0;
      upstream_empty         <= 1'b0;
      upstream_channel       <= '0;
      upstream_error         <= '0;
    end
  end
endmodule

// ---- testbench/tb_streaming_delay_line.sv ----
// self-checking bench: random stream through the delay, register slave
// assumes depth 3 with every option on; 50 MHz clock
module tb_streaming_delay_line;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DD = 3;
  localparam int DW = 16;
  localparam int CW = 4;
  localparam int EW = 2;
  localparam int LIM = 5;
  localparam int WW = DW + CW + EW + 4;
  logic aclk = 1'b0;
  logic aresetn, run, chk_on;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic upstream_valid, upstream_startofpacket, upstream_endofpacket;
  logic downstream_valid, downstream_startofpacket, downstream_endofpacket;
  logic upstream_empty, downstream_empty;
  logic [DW-1:0] upstream_data, downstream_data;
  logic [CW-1:0] upstream_channel, downstream_channel;
  logic [EW-1:0] upstream_error, downstream_error;
  logic [WW-1:0] pipe [DD];
  int error_cnt, num_checks, nb, ne, nr;
  logic over;
  wire [WW-1:0] up_w = {upstream_valid, upstream_data, upstream_empty,
    upstream_startofpacket, upstream_endofpacket, upstream_channel,
    upstream_error};
  wire [WW-1:0] dn_w = {downstream_valid, downstream_data, downstream_empty,
    downstream_startofpacket, downstream_endofpacket, downstream_channel,
    downstream_error};

  sdl_top #(.delay_depth(DD), .data_width(DW), .symbol_width(8),
    .packet_signals_enable(1'b1), .channel_signal_enable(1'b1),
    .channel_field_width(CW), .channel_count_limit(LIM),
    .error_signal_enable(1'b1), .error_field_width(EW)) u_dut (.*);
  sdl_st_partner #(.DW(DW), .CW(CW), .EW(EW)) u_src (.*);

  always #10 aclk = ~aclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // both halves offered together; response ready raised once it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready ||
               s_axi_wvalid && !s_axi_wready);
    do
      @(posedge aclk);
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    check(32'(s_axi_bresp), 32'(er), "bresp");
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    check(s_axi_rdata, ed, "rdata");
    check(32'(s_axi_rresp), 32'(er), "rresp");
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [31:0] exp_status(input logic ov);
    return (32'(DD) << sdl_pkg::STATUS_DEPTH_LSB) |
           (32'(ov) << sdl_pkg::STATUS_CHAN_OVER_BIT) | 32'h1;
  endfunction

  task automatic stream(input int n);
    run <= 1'b1;
    repeat (n) @(posedge aclk);
    run <= 1'b0;
    repeat (DD + 2) @(posedge aclk);
  endtask

  // reference delay: a cleared pipe of the configured depth
  always @(posedge aclk) begin
    for (int i = DD - 1; i > 0; i--)
      pipe[i] <= aresetn ? pipe[i-1] : '0;
    pipe[0] <= aresetn ? up_w : '0;
  end

  // expected counter values, rebuilt from every beat sent since reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      {nb, ne, nr} = '0;
      over = 1'b0;
    end else if (upstream_valid) begin
      nb++;
      ne += upstream_endofpacket;
      nr += (upstream_error != 0);
      over |= (upstream_channel > LIM);
    end
  end

  always @(negedge aclk) begin
    if (chk_on)
      check(32'(dn_w), 32'(pipe[DD-1]), "stream");
  end

  // a generous multiple of the few hundred cycles the tests need
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end

  initial begin
    void'($urandom(32'h5137));
    {aresetn, run, chk_on, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    @(posedge aclk);
    chk_on = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (DD + 1) @(posedge aclk);
    rd(sdl_pkg::CTRL_OFFSET, 32'h1, sdl_pkg::RESP_OKAY);
    rd(sdl_pkg::STATUS_OFFSET, exp_status(1'b0), sdl_pkg::RESP_OKAY);
    rd(8'h14, 32'h0, sdl_pkg::RESP_SLVERR);
    wr(8'h14, 32'h5, sdl_pkg::RESP_SLVERR);
    wr(sdl_pkg::STATUS_OFFSET, 32'hffffffff, sdl_pkg::RESP_OKAY);
    rd(sdl_pkg::STATUS_OFFSET, exp_status(1'b0), sdl_pkg::RESP_OKAY);
    $display("test registers done");
    stream(200);
    rd(sdl_pkg::BEAT_CNT_OFFSET, 32'(nb), sdl_pkg::RESP_OKAY);
    rd(sdl_pkg::PKT_CNT_OFFSET, 32'(ne), sdl_pkg::RESP_OKAY);
    rd(sdl_pkg::ERR_CNT_OFFSET, 32'(nr), sdl_pkg::RESP_OKAY);
    rd(sdl_pkg::STATUS_OFFSET, exp_status(over), sdl_pkg::RESP_OKAY);
    $display("test random stream done");
    wr(sdl_pkg::CTRL_OFFSET, 32'h2, sdl_pkg::RESP_OKAY);
    rd(sdl_pkg::CTRL_OFFSET, 32'h0, sdl_pkg::RESP_OKAY);
    stream(100);
    rd(sdl_pkg::BEAT_CNT_OFFSET, 32'h0, sdl_pkg::RESP_OKAY);
    wr(sdl_pkg::CTRL_OFFSET, 32'h1, sdl_pkg::RESP_OKAY);
    $display("test clear and hold done");
    run <= 1'b1;
    repeat (50) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    stream(60);
    rd(sdl_pkg::BEAT_CNT_OFFSET, 32'(nb), sdl_pkg::RESP_OKAY);
    $display("test reset in traffic done");
    test_done();
  end
endmodule
